/* File: shared/appmp_pkg.sv */
// Constants and types for the asynchronous parallel memory port
// How it works
// - Sixteen lines carry address then data; latch strobe marks the address phase.
// - Port moves either 8-bit or 16-bit data per external access.
// - In 8-bit width, latch strobe pulses an extra time, ahead of the low byte, when upper sixteen address bits change.
// - Latch strobe asserts every time a new address goes onto the lines.
// - Read strobe is low during each read, high otherwise.
// - Write strobe is low during each write, high otherwise.
// - When lines serve as flags, all three strobes stay inactive.
// - Latch strobe resets active high; software may select active low.
// - At reset lines float with pull-ups, read/write high, latch strobe low.
package appmp_pkg;
  localparam int          ADDR_W       = 24;
  localparam int          AD_W         = 16;
  localparam int          LOW_W        = 8;
  localparam int          CNT_W        = 5;
  localparam logic [4:0]  ADDR_CYCLES  = 5'h01;  // Address phase length
  localparam logic [4:0]  MIN_DATA_CYC = 5'h02;  // Least data phase length
  localparam logic [4:0]  DEF_DATA_CYC = 5'h02;  // Data phase when request gives less
  localparam logic [15:0] AD_ZERO      = 16'h0000;
  localparam logic [7:0]  BYTE_ZERO    = 8'h00;
  localparam logic [4:0]  CNT_ZERO     = 5'h00;
  localparam logic [4:0]  CNT_ONE      = 5'h01;

  typedef enum logic [2:0] {
    APPMP_IDLE,
    APPMP_UPPER,
    APPMP_ADDR,
    APPMP_DATA,
    APPMP_DONE
  } appmp_state_t;
endpackage : appmp_pkg

/* File: core/appmp_port.sv */
// Pin-level engine of the asynchronous parallel memory port
`timescale 1ns/10ps
`default_nettype none
module appmp_port
  import appmp_pkg::*;
(
  input  wire logic              core_clk,        // 10 MHz clock
  input  wire logic              rstn,            // Synchronous reset, active low
  input  wire logic              mode_16bit,      // 1: 16-bit data, 0: 8-bit data
  input  wire logic              ale_active_low,  // 1: latch strobe active low
  input  wire logic              flags_mode,      // Lines used as general flags
  input  wire logic [15:0]       flag_out,        // Flag values when in flag mode
  input  wire logic [15:0]       flag_oe,         // Flag drive enables
  input  wire logic [4:0]        data_cycles,     // Data phase length in clocks
  input  wire logic              req_valid,       // Access request
  input  wire logic              req_write,       // 1: write, 0: read
  input  wire logic [ADDR_W-1:0] req_addr,        // External address
  input  wire logic [15:0]       req_wdata,       // Write data
  output logic                   req_ready,       // High one cycle; the request was taken at the clock edge before
  output logic                   rsp_valid,       // Access finished, one cycle
  output logic [15:0]            rsp_rdata,       // Read data
  input  wire logic [15:0]       addr_data_lines_in,  // Line levels
  output logic [15:0]            addr_data_lines_out, // Line drive values
  output logic [15:0]            addr_data_lines_oe,  // Line drive enables
  output logic                   rd_n,            // Read strobe, active low
  output logic                   wr_n,            // Write strobe, active low
  output logic                   ale              // Address latch strobe
);

  // Sequencing state
  appmp_state_t      state_reg, state_next;
  logic [4:0]        cnt_reg, cnt_next;

  // Request held for the whole access
  logic              wr_reg, wr_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [15:0]       wdata_reg, wdata_next;
  logic [15:0]       upper_reg, upper_next;   // Upper bits held in external latch
  logic              upper_ok_reg, upper_ok_next;
  logic              m16_reg, m16_next;
  logic              ready_reg, ready_next;
  logic              rsp_reg, rsp_next;
  logic [15:0]       rdata_reg, rdata_next;

  // Pin registers, so every pin comes straight from a flip-flop
  logic [15:0]       ado_reg, ado_next;
  logic [15:0]       adoe_reg, adoe_next;
  logic              rdn_reg, rdn_next;
  logic              wrn_reg, wrn_next;
  logic              ale_reg, ale_next;

  // Derived values
  logic              ale_on;                  // Logical latch strobe level
  logic [4:0]        dlen;

  // Short data phases are stretched to the least legal length
  assign dlen = (data_cycles < MIN_DATA_CYC) ? DEF_DATA_CYC : data_cycles;

  // Next-state and pin computation
  always_comb begin
    state_next    = state_reg;
    cnt_next      = cnt_reg;
    wr_next       = wr_reg;
    addr_next     = addr_reg;
    wdata_next    = wdata_reg;
    upper_next    = upper_reg;
    upper_ok_next = upper_ok_reg;
    m16_next      = m16_reg;
    ready_next    = 1'b0;
    rsp_next      = 1'b0;
    rdata_next    = rdata_reg;
    ale_on        = 1'b0;
    rdn_next      = 1'b1;
    wrn_next      = 1'b1;
    ado_next      = ado_reg;
    adoe_next     = AD_ZERO;
    case (state_reg)
      APPMP_IDLE: begin
        // Take a request only when idle and the lines are not flags
        if (req_valid && !flags_mode && !ready_reg) begin
          ready_next = 1'b1;
          wr_next    = req_write;
          addr_next  = req_addr;
          wdata_next = req_wdata;
          m16_next   = mode_16bit;
          cnt_next   = ADDR_CYCLES;
          if (!mode_16bit &&
              (!upper_ok_reg || upper_reg != req_addr[ADDR_W-1:LOW_W])) begin
            // One extra cycle lets the strobe fall before the low byte goes out
            cnt_next   = ADDR_CYCLES + CNT_ONE;
            state_next = APPMP_UPPER;
          end else begin
            state_next = APPMP_ADDR;
          end
        end
      end
      APPMP_UPPER: begin
        // Upper bits go out first; the strobe drops for the last cycle so the
        // external latch closes on them before the low byte replaces them
        ale_on     = (cnt_reg != CNT_ONE);
        ado_next   = addr_reg[ADDR_W-1:LOW_W];
        adoe_next  = '1;
        upper_next = addr_reg[ADDR_W-1:LOW_W];
        upper_ok_next = 1'b1;
        if (cnt_reg == CNT_ONE) begin
          cnt_next   = ADDR_CYCLES;
          state_next = APPMP_ADDR;
        end else begin
          cnt_next = cnt_reg - CNT_ONE;
        end
      end
      APPMP_ADDR: begin
        // Address phase, strobe marks it
        // In 8-bit width only the low byte goes out, the upper bits sit in the latch
        ale_on    = 1'b1;
        adoe_next = '1;
        ado_next  = m16_reg ? addr_reg[AD_W-1:0] : {BYTE_ZERO, addr_reg[LOW_W-1:0]};
        if (cnt_reg == CNT_ONE) begin
          cnt_next   = dlen;
          state_next = APPMP_DATA;
        end else begin
          cnt_next = cnt_reg - CNT_ONE;
        end
      end
      APPMP_DATA: begin
        // Data phase, no strobe overlap with the address phase
        if (wr_reg) begin
          wrn_next  = 1'b0;
          // 8-bit writes drive the low byte only; the upper lines rest on pull-ups
          adoe_next = m16_reg ? '1 : {BYTE_ZERO, ~BYTE_ZERO};
          ado_next  = m16_reg ? wdata_reg : {BYTE_ZERO, wdata_reg[LOW_W-1:0]};
        end else begin
          rdn_next  = 1'b0;
        end
        if (cnt_reg == CNT_ONE) begin
          state_next = APPMP_DONE;
          rdn_next   = 1'b1;
          wrn_next   = 1'b1;
        end else begin
          cnt_next = cnt_reg - CNT_ONE;
        end
        // Read data is taken while the read strobe is low and the memory drives
        if (!wr_reg && !rdn_reg) begin
          rdata_next = m16_reg ? addr_data_lines_in
                               : {BYTE_ZERO, addr_data_lines_in[LOW_W-1:0]};
        end
      end
      APPMP_DONE: begin
        // One-cycle completion pulse
        rsp_next   = 1'b1;
        cnt_next   = CNT_ZERO;
        state_next = APPMP_IDLE;
      end
      default: begin
        state_next = APPMP_IDLE;
      end
    endcase
    // Flag use keeps strobes idle and hands lines to flag logic
    if (flags_mode && (state_reg == APPMP_IDLE)) begin
      ale_on    = 1'b0;
      rdn_next  = 1'b1;
      wrn_next  = 1'b1;
      ado_next  = flag_out;
      adoe_next = flag_oe;
    end
    // A strobe never meets the address phase, whatever the state
    if (ale_on) begin
      rdn_next = 1'b1;
      wrn_next = 1'b1;
    end
    // Polarity applied last, so the latch strobe follows the chosen level; read and write strobes stay active low
    ale_next = ale_on ^ ale_active_low;
  end

  // State registers
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      // Lines float, strobes idle, latch strobe low
      state_reg    <= APPMP_IDLE;
      cnt_reg      <= CNT_ZERO;
      wr_reg       <= 1'b0;
      addr_reg     <= '0;
      wdata_reg    <= AD_ZERO;
      upper_reg    <= AD_ZERO;
      upper_ok_reg <= 1'b0;
      m16_reg      <= 1'b0;
      ready_reg    <= 1'b0;
      rsp_reg      <= 1'b0;
      rdata_reg    <= AD_ZERO;
      ado_reg      <= AD_ZERO;
      adoe_reg     <= AD_ZERO;
      rdn_reg      <= 1'b1;
      wrn_reg      <= 1'b1;
      ale_reg      <= 1'b0;
    end else begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      wr_reg       <= wr_next;
      addr_reg     <= addr_next;
      wdata_reg    <= wdata_next;
      upper_reg    <= upper_next;
      upper_ok_reg <= upper_ok_next;
      m16_reg      <= m16_next;
      ready_reg    <= ready_next;
      rsp_reg      <= rsp_next;
      rdata_reg    <= rdata_next;
      ado_reg      <= ado_next;
      adoe_reg     <= adoe_next;
      rdn_reg      <= rdn_next;
      wrn_reg      <= wrn_next;
      ale_reg      <= ale_next;
    end
  end

  // Outputs straight from the registers
  assign req_ready           = ready_reg;
  assign rsp_valid           = rsp_reg;
  assign rsp_rdata           = rdata_reg;
  assign addr_data_lines_out = ado_reg;
  assign addr_data_lines_oe  = adoe_reg;
  assign rd_n                = rdn_reg;
  assign wr_n                = wrn_reg;
  assign ale                 = ale_reg;

endmodule : appmp_port
`default_nettype wire

/* File: bench/appmp_mem_model.sv */
// External address latch and memory facing the parallel port
`timescale 1ns/10ps
`default_nettype none
module appmp_mem_model (
  input  wire logic        core_clk, // Clock
  input  wire logic [15:0] lines,    // Resolved line levels
  input  wire logic        ale_on,   // Latch strobe, logical
  input  wire logic        rd_n,     // Read strobe
  input  wire logic        wr_n,     // Write strobe
  output logic      [15:0] drv,        // Read data
  output logic             drv_oe,     // Read data enable
  output logic      [15:0] upper_held  // Upper address bits held in the latch
);
  logic [15:0] lat_reg;
  logic [15:0] prev_reg;
  logic        ale_d  = 1'b0;
  int          npulse = 0;
  logic [15:0] mem [0:255];
  // Known contents so reads of unwritten words are predictable
  initial for (int i = 0; i < 256; i++) mem[i] = {~i[7:0], i[7:0]};
  // Latch closes on each strobe pulse; with two pulses before an access the
  // first carried the upper bits, which stay held for later accesses
  always @(posedge core_clk) begin
    ale_d <= ale_on;
    if (ale_on && !ale_d) begin
      prev_reg <= lat_reg;
      lat_reg  <= lines;
      npulse   <= npulse + 1;
    end
    if (!rd_n || !wr_n) begin
      if (npulse == 2) upper_held <= prev_reg;
      npulse <= 0;
    end
    if (!wr_n) mem[lat_reg[7:0]] <= lines;
  end
  // Drives only under the read strobe, else lines float to pull-ups
  assign drv    = mem[lat_reg[7:0]];
  assign drv_oe = !rd_n;
endmodule : appmp_mem_model
`default_nettype wire

/* File: bench/appmp_port_chk.sv */
// Assertion checker for the parallel memory port
`timescale 1ns/10ps
`default_nettype none
module appmp_port_chk (
  input wire logic        core_clk,           // Clock
  input wire logic        rstn,               // Reset
  input wire logic        ale_active_low,     // Strobe polarity
  input wire logic        flags_mode,         // Flag use
  input wire logic        req_valid,          // Request
  input wire logic        req_ready,          // Taken
  input wire logic        rsp_valid,          // Done
  input wire logic [15:0] addr_data_lines_oe, // Line enables
  input wire logic        rd_n,               // Read strobe
  input wire logic        wr_n,               // Write strobe
  input wire logic        ale                 // Latch strobe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Request accepted, then its address phase
  sequence s_take; req_valid && !req_ready ##1 req_ready; endsequence
  sequence s_strobe; ale ^ $past(ale_active_low); endsequence
  property p_take; s_take |=> (ale ^ $past(ale_active_low)) && addr_data_lines_oe == 16'hFFFF; endproperty
  property p_addr; s_strobe |-> addr_data_lines_oe == 16'hFFFF; endproperty
  property p_gap; s_strobe |=> !(ale ^ $past(ale_active_low)); endproperty
  property p_resp; s_take |-> ##[3:40] rsp_valid; endproperty
  property p_excl; !(!rd_n && !wr_n); endproperty
  property p_phase; (ale ^ $past(ale_active_low)) |-> rd_n && wr_n; endproperty
  property p_rd; !rd_n |-> addr_data_lines_oe == 16'h0000; endproperty
  property p_wr; !wr_n |-> addr_data_lines_oe[7:0] == 8'hFF; endproperty
  property p_flag; flags_mode [*3] |-> rd_n && wr_n && ale == $past(ale_active_low); endproperty
  property p_pulse; req_ready |=> !req_ready; endproperty
  a_take: assert property (p_take) else $error("address phase wrong");
  a_resp: assert property (p_resp) else $error("no response");
  a_excl: assert property (p_excl) else $error("strobes overlap");
  a_phase: assert property (p_phase) else $error("strobe in address phase");
  a_rd: assert property (p_rd) else $error("driving during read");
  a_wr: assert property (p_wr) else $error("not driving during write");
  a_flag: assert property (p_flag) else $error("strobe in flag use");
  a_pulse: assert property (p_pulse) else $error("ready too long");
  a_addr: assert property (p_addr) else $error("lines not driven in address phase");
  a_gap: assert property (p_gap) else $error("latch strobe longer than one cycle");
endmodule : appmp_port_chk
`default_nettype wire

/* File: bench/appmp_port_tb_top.sv */
// Testbench for the parallel memory port
`timescale 1ns/10ps
`default_nettype none
module appmp_port_tb_top;
  import appmp_pkg::*;
  logic core_clk = 0, rstn = 0, mode_16bit = 1, ale_active_low = 0, flags_mode = 0;
  logic req_valid = 0, req_write = 0, req_ready, rsp_valid, rd_n, wr_n, ale, m_oe;
  logic [15:0] flag_out = 0, flag_oe = 0, req_wdata = 0, rsp_rdata, d_out, d_oe, m_drv, m_up;
  logic [4:0] data_cycles = 0;
  logic [23:0] req_addr = 0;
  wire logic [15:0] lines;
  int mismatches = 0, checks = 0, cyc = 0, na, nl;
  always #50 core_clk = ~core_clk;
  // Pull-ups win where nobody drives
  assign lines = (d_oe & d_out) | (~d_oe & (m_oe ? m_drv : 16'hFFFF));
  appmp_port dut_u (.core_clk(core_clk), .rstn(rstn), .mode_16bit(mode_16bit), .ale_active_low(ale_active_low),
    .flags_mode(flags_mode), .flag_out(flag_out), .flag_oe(flag_oe), .data_cycles(data_cycles),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .addr_data_lines_in(lines),
    .addr_data_lines_out(d_out), .addr_data_lines_oe(d_oe), .rd_n(rd_n), .wr_n(wr_n), .ale(ale));
  appmp_mem_model mem_u (.core_clk(core_clk), .lines(lines), .ale_on(ale ^ ale_active_low), .rd_n(rd_n),
    .wr_n(wr_n), .drv(m_drv), .drv_oe(m_oe), .upper_held(m_up));
  task automatic check(input string n, input logic [23:0] g, input logic [23:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask : check
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  // One access; counts latch pulses and strobe-low cycles until done
  task automatic xfer(input logic w, input logic [23:0] a, input logic [15:0] d, input logic m, input logic [4:0] dc);
    na = 0;
    nl = 0;
    @(negedge core_clk);
    {req_valid, req_write, req_addr, req_wdata, mode_16bit, data_cycles} = {1'b1, w, a, d, m, dc};
    for (int i = 0; i < 60 && rsp_valid !== 1'b1; i++) begin
      @(negedge core_clk);
      if (req_ready) req_valid = 0;
      na += (ale ^ ale_active_low);
      nl += (!rd_n || !wr_n);
    end
    check("rsp", rsp_valid, 1'b1);
  endtask : xfer
  task automatic t_wide;
    xfer(1, 24'h000012, 16'h1234, 1, 5'h03);
    check("ale16", na, 1);
    check("wrlow", nl, 2);
    xfer(0, 24'h000012, 16'h0000, 1, 5'h03);
    check("rd16", rsp_rdata, 16'h1234);
    check("rdlow", nl, 2);
  endtask : t_wide
  task automatic t_narrow;
    xfer(1, 24'h123456, 16'h005A, 0, 5'h00);
    check("newup", na, 2);
    check("mindata", nl, 1);
    check("uplatch", m_up, 16'h1234);
    xfer(0, 24'h123456, 16'h0000, 0, 5'h02);
    check("sameup", na, 1);
    check("rd8", rsp_rdata, 16'h005A);
    check("upkeep", m_up, 16'h1234);
    xfer(0, 24'h223480, 16'h0000, 0, 5'h02);
    check("chgup", na, 2);
    check("rd8b", rsp_rdata, 16'h0080);
    check("upnew", m_up, 16'h2234);
  endtask : t_narrow
  task automatic t_pol;
    ale_active_low = 1;
    repeat (2) @(negedge core_clk);
    check("idlelow", ale, 1);
    xfer(1, 24'h000034, 16'hBEEF, 1, 5'h02);
    check("alelow", na, 1);
    ale_active_low = 0;
  endtask : t_pol
  task automatic t_flags;
    {flags_mode, flag_out, flag_oe, req_valid, mode_16bit} = {1'b1, 16'hA5A5, 16'hFF00, 1'b1, 1'b1};
    na = 0;
    repeat (5) @(negedge core_clk) na += req_ready;
    check("noreq", na, 0);
    check("flaglines", lines, 16'hA5FF);
    check("strobes", {rd_n, wr_n, ale}, 3'b110);
    {flags_mode, req_valid} = 2'b00;
    xfer(0, 24'h000034, 16'h0000, 1, 5'h02);
    check("rdback", rsp_rdata, 16'hBEEF);
  endtask : t_flags
  // Cuts a hang short
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      wrap_up();
    end
  end
  initial begin
    repeat (4) @(negedge core_clk);
    check("rstlines", lines, 16'hFFFF);
    check("rststrb", {rd_n, wr_n, ale}, 3'b110);
    rstn = 1;
    t_wide();
    t_narrow();
    t_pol();
    t_flags();
    wrap_up();
  end
endmodule : appmp_port_tb_top
bind appmp_port appmp_port_chk chk_u (.core_clk(core_clk), .rstn(rstn), .ale_active_low(ale_active_low),
  .flags_mode(flags_mode), .req_valid(req_valid), .req_ready(req_ready), .rsp_valid(rsp_valid),
  .addr_data_lines_oe(addr_data_lines_oe), .rd_n(rd_n), .wr_n(wr_n), .ale(ale));
`default_nettype wire
